// File: pkg/pfc_pkg.sv
// pfc_pkg: shared constants, register map and types of the thermostat stage control
// assumes temperatures in tenths of a degree, signed 16 bit, evaluation on a periodic tick
package pfc_pkg;
	// register byte offsets on the apb slave
	localparam logic [7:0] PFC_REG_CTRL = 8'h00; // mode, speeds, step, valve format
	localparam logic [7:0] PFC_REG_SETPOINT = 8'h04; // setpoint, tenths of a degree
	localparam logic [7:0] PFC_REG_TEMP = 8'h08; // measured temperature
	localparam logic [7:0] PFC_REG_BAND = 8'h0C; // proportional band, tenths
	localparam logic [7:0] PFC_REG_INTEG = 8'h10; // integral gain shift, 0 = none
	localparam logic [7:0] PFC_REG_VALVE_DIFF = 8'h14; // valve differential
	localparam logic [7:0] PFC_REG_HEAT_DIFF = 8'h18; // three heat differentials, bytes
	localparam logic [7:0] PFC_REG_COOL_DIFF = 8'h1C; // three cool differentials, bytes
	localparam logic [7:0] PFC_REG_STATUS = 8'h20; // outputs, read only
	localparam logic [7:0] PFC_REG_HOLDOFF = 8'h24; // hold-off in ticks
	// control field positions
	localparam int PFC_CTRL_COOL_BIT = 0; // 1 = cooling
	localparam int PFC_CTRL_FAN_BIT = 1; // 1 = fancoil, 0 = continuous
	localparam int PFC_CTRL_NSPD_LSB = 2; // number of speeds, 2 bits
	localparam int PFC_CTRL_STEP_LSB = 4; // step select, 3 bits
	localparam int PFC_CTRL_PCT_BIT = 7; // valve as 0/100 percent
	localparam int PFC_CTRL_ENABLE_BIT = 8; // run the controller
	localparam logic [8:0] PFC_CTRL_RESET = 9'h018; // disabled, heat, 2 speeds, 2% step
	localparam logic [15:0] PFC_DIFF_RESET = 16'h0002; // 0.2 degree
	localparam logic [15:0] PFC_BAND_RESET = 16'h0014; // 2.0 degree
	localparam logic [23:0] PFC_STAGE_RESET = 24'h020202;
	localparam logic [7:0] PFC_PCT_FULL = 8'h64; // 100 percent
	localparam logic [31:0] PFC_UNMAPPED = 32'h0000_0000;
	// timing
	localparam int PFC_CLK_HZ = 25_000_000;
	localparam int PFC_HOLDOFF_S = 120; // two minutes
	localparam longint PFC_HOLDOFF_CYC = longint'(PFC_HOLDOFF_S) * PFC_CLK_HZ;
	localparam logic [15:0] PFC_TICK_DIV = 16'h61A8; // 1 ms evaluation tick at 25 MHz
	localparam logic [23:0] PFC_HOLDOFF_TICKS = 24'h01D4C0; // 120000 ms
	// step table: 1,2,3,4,5,10,20 percent
	function automatic logic [7:0] pfc_step(input logic [2:0] sel);
		case (sel)
			3'h0: pfc_step = 8'h01;
			3'h1: pfc_step = 8'h02;
			3'h2: pfc_step = 8'h03;
			3'h3: pfc_step = 8'h04;
			3'h4: pfc_step = 8'h05;
			3'h5: pfc_step = 8'h0A;
			default: pfc_step = 8'h14;
		endcase
	endfunction : pfc_step
	typedef enum logic [1:0] {PFC_SPD_OFF, PFC_SPD_LOW, PFC_SPD_MID, PFC_SPD_HIGH} pfc_speed_t;
endpackage : pfc_pkg

// File: pkg/pfc_cfg_if.sv
// pfc_cfg_if: configuration and status carried between the top and its pi worker
// assumes one clock domain; the top derives its fields from its registers, the pi registers pct_q and pct_send
`timescale 1ns/10ps
interface pfc_cfg_if;
	logic tick; // evaluation strobe
	logic cool; // cooling when high
	logic signed [15:0] error; // setpoint minus temperature
	logic [15:0] band; // proportional band
	logic [3:0] integ_shift; // integral divider, 0 disables
	logic [7:0] step; // minimum step percent
	logic [7:0] pct_q; // last sent percentage
	logic pct_send; // one-cycle send pulse
	modport top (output tick, cool, error, band, integ_shift, step, input pct_q, pct_send);
	modport pi (input tick, cool, error, band, integ_shift, step, output pct_q, pct_send);
endinterface : pfc_cfg_if

// File: verilog/pfc_pi.sv
// pfc_pi: continuous proportional-integral output, clipped and quantised into steps
// assumes error is setpoint minus temperature, positive demands heat
`timescale 1ns/10ps
module pfc_pi (
	input wire logic pclk,
	input wire logic presetn,
	pfc_cfg_if.pi cfg
);
	import pfc_pkg::*;
	logic signed [31:0] integ_q; // accumulated error
	logic signed [31:0] dem; // demand, positive toward full power
	logic signed [31:0] raw; // proportional plus integral
	logic [7:0] pct; // clipped percentage
	logic [7:0] lvl; // quantised level
	logic [7:0] diff; // distance to last sent
	// cooling inverts the sense of the error
	assign dem = cfg.cool ? -32'(cfg.error) : 32'(cfg.error);
	// accumulate only on ticks, clamped to the band so it cannot wind up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			integ_q <= '0;
		end else if (cfg.tick && cfg.integ_shift != 4'h0) begin
			// signed compare, so a negative sum clamps to zero and not to the top
			if (integ_q + dem > $signed(32'(cfg.band)) <<< cfg.integ_shift) begin
				integ_q <= 32'(cfg.band) <<< cfg.integ_shift;
			end else if (integ_q + dem < 0) begin
				integ_q <= '0;
			end else begin
				integ_q <= integ_q + dem; // RULE1
			end
		end else if (cfg.integ_shift == 4'h0) begin
			integ_q <= '0; // no integral
		end
	end
	// output = kp*e + ki*int, scaled so the band spans 0..100
	always_comb begin
		raw = dem + (integ_q >>> cfg.integ_shift); // RULE1
		if (raw <= 0) begin
			pct = 8'h00; // RULE2
		end else if (raw >= 32'(cfg.band)) begin
			pct = PFC_PCT_FULL; // RULE2
		end else begin
			pct = 8'((raw * 100) / 32'(cfg.band)); // RULE2
		end
		lvl = 8'((pct / cfg.step) * cfg.step); // RULE3
		diff = (lvl > cfg.pct_q) ? lvl - cfg.pct_q : cfg.pct_q - lvl;
	end
	// send only when a new level differs by at least one step
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg.pct_q <= 8'h00;
			cfg.pct_send <= 1'b0;
		end else begin
			cfg.pct_send <= 1'b0;
			if (cfg.tick && diff >= cfg.step) begin
				cfg.pct_q <= lvl; // RULE16
				cfg.pct_send <= 1'b1; // RULE3
			end
		end
	end
endmodule : pfc_pi

// File: verilog/pfc_fan.sv
// pfc_fan: staged fancoil speed and solenoid valve hysteresis
// assumes the top supplies the demand dev already referenced to the error sign; thresholds are built here from the differentials
`timescale 1ns/10ps
module pfc_fan (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic tick,
	input wire logic enable,
	input wire logic signed [15:0] dev, // demand: setpoint-temp (heat) or temp-setpoint
	input wire logic [15:0] valve_diff,
	input wire logic [47:0] stage_diff, // three 16-bit differentials, stage one low
	input wire logic [1:0] nspeeds,
	input wire logic hold_ok, // hold-off expired
	output logic valve_q,
	output pfc_pkg::pfc_speed_t speed_q
);
	import pfc_pkg::*;
	logic signed [17:0] on_th [3]; // turn-on thresholds per stage
	logic signed [17:0] off_th [3]; // turn-off thresholds per stage
	logic [2:0] want; // per-stage hysteresis view
	pfc_speed_t target;
	// thresholds per stage, built once in a loop
	genvar g;
	for (g = 0; g < 3; g++) begin : g_thr
		if (g == 0) begin : g_first
			// stage one falls back to the setpoint when its differential is zero
			assign off_th[g] = (stage_diff[15:0] == 16'h0000) ? 18'sd0 :
				$signed(18'(valve_diff)); // RULE6
			assign on_th[g] = $signed(18'(valve_diff) + 18'(stage_diff[15:0])); // RULE4
		end else begin : g_rest
			assign off_th[g] = on_th[g-1]; // RULE7 RULE8 RULE11 RULE12
			assign on_th[g] = 18'(on_th[g-1] + $signed(18'(stage_diff[16*g +: 16]))); // RULE4
		end
		// hold on between off and on thresholds, switch at the edges
		assign want[g] = (dev > on_th[g]) ? 1'b1 :
			(dev <= off_th[g]) ? 1'b0 : (speed_q > pfc_speed_t'(g)); // RULE4
	end
	// highest stage needed wins, clipped to configured speeds
	always_comb begin
		if (want[2] && nspeeds >= 2'h3) target = PFC_SPD_HIGH; // RULE15
		else if (want[1] && nspeeds >= 2'h2) target = PFC_SPD_MID; // RULE15
		else if (want[0] && nspeeds >= 2'h1) target = PFC_SPD_LOW;
		else target = PFC_SPD_OFF;
	end
	// one enum register makes speeds mutually exclusive; turning up waits for hold-off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			speed_q <= PFC_SPD_OFF;
		end else if (!enable) begin
			speed_q <= PFC_SPD_OFF;
		end else if (tick && target != speed_q) begin
			if (target < speed_q || hold_ok) begin
				speed_q <= target; // RULE5 RULE14
			end
		end
	end
	// valve: on past the valve differential, off at the setpoint
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			valve_q <= 1'b0;
		end else if (!enable) begin
			valve_q <= 1'b0;
		end else if (tick) begin
			// signed compare: a negative demand must never open the valve
			if (dev > $signed(18'(valve_diff)) && hold_ok) begin
				valve_q <= 1'b1; // RULE9 RULE13 RULE14
			end else if (dev <= 0) begin
				valve_q <= 1'b0; // RULE9 RULE13
			end
		end
	end
endmodule : pfc_fan

// File: verilog/pfc_top.sv
// pfc_top: thermostat stage control with apb registers, pi output and fancoil stages
// assumes apb master on pclk; temperatures written by software in tenths of a degree
// Operation
// RULE1: output is proportional plus integral of error
// RULE2: band spans 0-100, saturates outside
// RULE3: send percentage only on level crossings
// RULE4: up to three speeds, own hysteresis
// RULE5: other speeds off before new speed (the code switches the old speed off and the new one on at the same pclk edge)
// RULE6: heat low speed thresholds below setpoint
// RULE7: heat mid speed thresholds below setpoint
// RULE8: heat high speed thresholds below setpoint
// RULE9: heat valve on below valve differential
// RULE10: cool low speed thresholds above setpoint
// RULE11: cool mid speed thresholds above setpoint
// RULE12: cool high speed thresholds above setpoint
// RULE13: cool valve on above valve differential
// RULE14: hold off activations up to two minutes
// RULE15: drive only configured lower speeds
// RULE16: step selectable 1..20, minimum change sent
// RULE17: valve as switch or 0/100 percent
//
// The register addresses and register access over APB were decided locally.
`timescale 1ns/10ps
module pfc_top #(
	parameter logic [23:0] HOLDOFF_TICKS = pfc_pkg::PFC_HOLDOFF_TICKS,
	parameter logic [15:0] TICK_DIV = pfc_pkg::PFC_TICK_DIV
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [7:0] valve_pct, // continuous or 0/100 valve command
	output logic valve_pct_send, // one-cycle pulse with a new percentage
	output logic heat_valve_on, // heating solenoid valve switch
	output logic cool_valve_on, // cooling solenoid valve switch
	output logic fan_speed_low,
	output logic fan_speed_mid,
	output logic fan_speed_high
);
	import pfc_pkg::*;
	pfc_cfg_if cfg ();
	// configuration registers
	logic [8:0] ctrl_q; // control word
	logic signed [15:0] setpoint_q; // setpoint
	logic signed [15:0] temp_q; // measured temperature
	logic [15:0] band_q; // proportional band
	logic [3:0] integ_q; // integral shift
	logic [15:0] valve_diff_q; // valve differential
	logic [23:0] heat_diff_q; // heat stage differentials
	logic [23:0] cool_diff_q; // cool stage differentials
	logic [15:0] tick_cnt_q; // evaluation tick divider
	logic tick_q; // evaluation strobe
	logic [23:0] hold_cnt_q; // ticks since the valve last turned off
	logic hold_ok; // hold-off elapsed
	logic wr_en; // apb write in access phase
	logic valve_on; // fan valve state
	pfc_speed_t speed; // fan speed state
	logic valve_prev_q; // last valve state for edge
	logic [47:0] stage_diff; // selected differentials widened
	logic [23:0] sel_diff; // selected stage bytes
	logic signed [15:0] dev; // demand seen by fan logic

	assign wr_en = psel && penable && pwrite;
	// zero-wait slave, never errors
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	// register writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= PFC_CTRL_RESET;
			setpoint_q <= '0;
			temp_q <= '0;
			band_q <= PFC_BAND_RESET;
			integ_q <= 4'h0;
			valve_diff_q <= PFC_DIFF_RESET;
			heat_diff_q <= PFC_STAGE_RESET;
			cool_diff_q <= PFC_STAGE_RESET;
		end else if (wr_en) begin
			case (paddr)
				PFC_REG_CTRL: ctrl_q <= pwdata[8:0];
				PFC_REG_SETPOINT: setpoint_q <= pwdata[15:0];
				PFC_REG_TEMP: temp_q <= pwdata[15:0];
				PFC_REG_BAND: begin
					// a zero band would divide by zero, keep the old value
					if (pwdata[15:0] != 16'h0000) band_q <= pwdata[15:0];
				end
				PFC_REG_INTEG: integ_q <= pwdata[3:0];
				PFC_REG_VALVE_DIFF: valve_diff_q <= pwdata[15:0];
				PFC_REG_HEAT_DIFF: heat_diff_q <= pwdata[23:0];
				PFC_REG_COOL_DIFF: cool_diff_q <= pwdata[23:0];
				default: ; // read-only and unmapped writes ignored
			endcase
		end
	end

	// read mux, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				PFC_REG_CTRL: prdata <= {23'h0, ctrl_q};
				PFC_REG_SETPOINT: prdata <= {16'h0, setpoint_q};
				PFC_REG_TEMP: prdata <= {16'h0, temp_q};
				PFC_REG_BAND: prdata <= {16'h0, band_q};
				PFC_REG_INTEG: prdata <= {28'h0, integ_q};
				PFC_REG_VALVE_DIFF: prdata <= {16'h0, valve_diff_q};
				PFC_REG_HEAT_DIFF: prdata <= {8'h0, heat_diff_q};
				PFC_REG_COOL_DIFF: prdata <= {8'h0, cool_diff_q};
				PFC_REG_STATUS: prdata <= {16'h0, valve_pct, 2'h0, valve_on, hold_ok,
					2'h0, speed};
				PFC_REG_HOLDOFF: prdata <= {8'h0, hold_cnt_q};
				default: prdata <= PFC_UNMAPPED;
			endcase
		end
	end

	// evaluation tick divider; a long hold-off counts ticks, not clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end else if (tick_cnt_q >= TICK_DIV - 16'h0001) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b1;
		end else begin
			tick_cnt_q <= tick_cnt_q + 16'h0001;
			tick_q <= 1'b0;
		end
	end

	// hold-off restarts whenever the valve turns off, gating the next activation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_cnt_q <= HOLDOFF_TICKS; // first activation needs no wait
			valve_prev_q <= 1'b0;
		end else begin
			valve_prev_q <= valve_on;
			if (valve_prev_q && !valve_on) begin
				hold_cnt_q <= '0; // RULE14
			end else if (tick_q && hold_cnt_q < HOLDOFF_TICKS) begin
				hold_cnt_q <= hold_cnt_q + 24'h000001;
			end
		end
	end
	assign hold_ok = (hold_cnt_q >= HOLDOFF_TICKS);

	// feed the pi worker
	assign cfg.tick = tick_q && ctrl_q[PFC_CTRL_ENABLE_BIT] && !ctrl_q[PFC_CTRL_FAN_BIT];
	assign cfg.cool = ctrl_q[PFC_CTRL_COOL_BIT];
	assign cfg.error = 16'(setpoint_q - temp_q);
	assign cfg.band = band_q;
	assign cfg.integ_shift = integ_q;
	assign cfg.step = pfc_step(ctrl_q[PFC_CTRL_STEP_LSB +: 3]); // RULE16

	pfc_pi u_pi (
		.pclk(pclk),
		.presetn(presetn),
		.cfg(cfg.pi)
	);

	// fan worker sees demand with sign folded so both modes compare alike
	assign dev = ctrl_q[PFC_CTRL_COOL_BIT] ? 16'(temp_q - setpoint_q) : 16'(setpoint_q - temp_q);
	assign sel_diff = ctrl_q[PFC_CTRL_COOL_BIT] ? cool_diff_q : heat_diff_q; // RULE10
	assign stage_diff = {8'h0, sel_diff[23:16], 8'h0, sel_diff[15:8], 8'h0, sel_diff[7:0]};

	pfc_fan u_fan (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick_q),
		.enable(ctrl_q[PFC_CTRL_ENABLE_BIT] && ctrl_q[PFC_CTRL_FAN_BIT]),
		.dev(dev),
		.valve_diff(valve_diff_q),
		.stage_diff(stage_diff),
		.nspeeds(ctrl_q[PFC_CTRL_NSPD_LSB +: 2]),
		.hold_ok(hold_ok),
		.valve_q(valve_on),
		.speed_q(speed)
	);

	// outputs from flip-flops; valve percent reflects fancoil format or pi value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			valve_pct <= 8'h00;
			valve_pct_send <= 1'b0;
			heat_valve_on <= 1'b0;
			cool_valve_on <= 1'b0;
			fan_speed_low <= 1'b0;
			fan_speed_mid <= 1'b0;
			fan_speed_high <= 1'b0;
		end else begin
			if (ctrl_q[PFC_CTRL_FAN_BIT]) begin
				// percent form only when selected, else switch outputs carry it
				// the percentage moves only together with its send strobe
				if (ctrl_q[PFC_CTRL_PCT_BIT] && (valve_on != valve_prev_q)) begin
					valve_pct <= valve_on ? PFC_PCT_FULL : 8'h00; // RULE17
				end
				valve_pct_send <= ctrl_q[PFC_CTRL_PCT_BIT] && (valve_on != valve_prev_q); // RULE17
				heat_valve_on <= !ctrl_q[PFC_CTRL_PCT_BIT] && valve_on && !cfg.cool; // RULE9
				cool_valve_on <= !ctrl_q[PFC_CTRL_PCT_BIT] && valve_on && cfg.cool; // RULE13
			end else begin
				// a mode change must not move the level without a telegram
				if (cfg.pct_send) begin
					valve_pct <= cfg.pct_q; // RULE3
				end
				valve_pct_send <= cfg.pct_send;
				heat_valve_on <= 1'b0;
				cool_valve_on <= 1'b0;
			end
			fan_speed_low <= (speed == PFC_SPD_LOW); // RULE5
			fan_speed_mid <= (speed == PFC_SPD_MID); // RULE5
			fan_speed_high <= (speed == PFC_SPD_HIGH); // RULE5
		end
	end
endmodule : pfc_top

// File: testbench/pfc_top_asserts.sv
// pfc_top_asserts: port-level checks of the thermostat stage control
// assumes it is bound to pfc_top, one pclk domain, presetn async active low
`timescale 1ns/10ps
module pfc_top_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] valve_pct,
	input wire logic valve_pct_send,
	input wire logic heat_valve_on,
	input wire logic cool_valve_on,
	input wire logic fan_speed_low,
	input wire logic fan_speed_mid,
	input wire logic fan_speed_high
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// a send strobe lasts exactly one cycle
	sequence s_send_once;
		valve_pct_send ##1 !valve_pct_send;
	endsequence
	// read setup above the map, then its access cycle
	sequence s_rd_unmapped;
		psel && !penable && !pwrite && paddr > 8'h24 ##1 psel && penable;
	endsequence
	a_speed_one_hot: assert property ($onehot0({fan_speed_high, fan_speed_mid, fan_speed_low}))
		else $error("more than one fan speed active");
	a_valves_apart: assert property (!(heat_valve_on && cool_valve_on))
		else $error("heat and cool valves both on");
	a_send_single: assert property (valve_pct_send |-> s_send_once)
		else $error("send strobe longer than one cycle");
	a_pct_in_range: assert property (valve_pct <= 8'h64)
		else $error("valve percentage above full");
	a_pct_only_sent: assert property ($changed(valve_pct) |-> valve_pct_send)
		else $error("valve percentage moved without a send");
	a_ready_always: assert property (psel |-> pready)
		else $error("apb slave stalled");
	a_no_slave_err: assert property (psel && penable |-> !pslverr)
		else $error("apb error response");
	a_unmapped_zero: assert property (s_rd_unmapped |-> prdata == 32'h0000_0000)
		else $error("unmapped read not zero");
	// the top speed is reached at least once
	c_high_speed: cover property (fan_speed_high);
endmodule : pfc_top_asserts

bind pfc_top pfc_top_asserts pfc_top_asserts_i (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .valve_pct(valve_pct), .valve_pct_send(valve_pct_send),
	.heat_valve_on(heat_valve_on), .cool_valve_on(cool_valve_on),
	.fan_speed_low(fan_speed_low), .fan_speed_mid(fan_speed_mid),
	.fan_speed_high(fan_speed_high));

// File: testbench/pfc_act_model.sv
// pfc_act_model: percentage actuator on the far side, keeps the last command
// assumes a command is valid only in the cycle of its send strobe
`timescale 1ns/10ps
module pfc_act_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] valve_pct,
	input wire logic valve_pct_send,
	output logic [7:0] last_pct,
	output int unsigned num_cmds
);
	// latch a telegram only on its strobe; the level between strobes means nothing
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_pct <= 8'h00;
			num_cmds <= 0;
		end else if (valve_pct_send) begin
			last_pct <= valve_pct;
			num_cmds <= num_cmds + 1;
		end
	end
endmodule : pfc_act_model

// File: testbench/tb.sv
// tb: self-checking bench of pfc_top over apb, with a percentage actuator model
// assumes short tick and hold-off parameters so that each step settles in 100 cycles
`timescale 1ns/10ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
	$display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb;
	import pfc_pkg::*;
	logic pclk = 1'b0; // 25 MHz
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd, st;
	logic pready, pslverr, valve_pct_send, heat_valve_on, cool_valve_on;
	logic fan_speed_low, fan_speed_mid, fan_speed_high;
	logic [7:0] valve_pct, last_pct;
	int unsigned num_cmds, n0;
	int num_errors = 0;
	int samples_checked = 0;
	// one fancoil case: config, temperature and the outputs it must give
	typedef struct packed {logic [8:0] ctrl; logic [15:0] temp; logic hv; logic cv;
		logic [2:0] spd;} pfc_row_t;
	pfc_row_t rows [11];
	logic [7:0] ra [7];
	logic [31:0] rv [7];
	always #20 pclk = ~pclk;
	pfc_top #(.HOLDOFF_TICKS(24'h000008), .TICK_DIV(16'h0004)) pfc_top_i (.pclk(pclk),
		.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.valve_pct(valve_pct), .valve_pct_send(valve_pct_send), .heat_valve_on(heat_valve_on),
		.cool_valve_on(cool_valve_on), .fan_speed_low(fan_speed_low),
		.fan_speed_mid(fan_speed_mid), .fan_speed_high(fan_speed_high));
	pfc_act_model pfc_act_model_i (.pclk(pclk), .presetn(presetn), .valve_pct(valve_pct),
		.valve_pct_send(valve_pct_send), .last_pct(last_pct), .num_cmds(num_cmds));
	// verdict and end of run, also reached by a timed-out wait
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out
	// one apb transfer; held until pready is seen high, read data taken there
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 64);
		if (n >= 64) begin
			num_errors++;
			close_out();
		end else begin
			rd = prdata;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb
	// set mode and temperature, then let ticks and hold-off run out
	task automatic drive(input logic [8:0] c, input logic [15:0] t);
		apb(1'b1, PFC_REG_CTRL, {23'h000000, c});
		apb(1'b1, PFC_REG_TEMP, {16'h0000, t});
		repeat (100) @(posedge pclk);
		@(negedge pclk);
	endtask : drive
	initial begin
		ra = '{PFC_REG_CTRL, PFC_REG_BAND, PFC_REG_VALVE_DIFF, PFC_REG_HEAT_DIFF,
			PFC_REG_COOL_DIFF, PFC_REG_INTEG, 8'h40};
		rv = '{32'(PFC_CTRL_RESET), 32'(PFC_BAND_RESET), 32'(PFC_DIFF_RESET),
			32'(PFC_STAGE_RESET), 32'(PFC_STAGE_RESET), 32'h0000_0000, PFC_UNMAPPED};
		// heat rows climb the stages, then fall back; cool rows jump to high speed and back to off; last row has one speed
		rows = '{'{9'h10E, 16'h00C8, 1'b0, 1'b0, 3'h0}, '{9'h10E, 16'h00C5, 1'b1, 1'b0, 3'h0},
			'{9'h10E, 16'h00C3, 1'b1, 1'b0, 3'h1}, '{9'h10E, 16'h00C1, 1'b1, 1'b0, 3'h2},
			'{9'h10E, 16'h00BF, 1'b1, 1'b0, 3'h4}, '{9'h10E, 16'h00C7, 1'b1, 1'b0, 3'h0},
			'{9'h10E, 16'h00C8, 1'b0, 1'b0, 3'h0}, '{9'h10F, 16'h00CB, 1'b0, 1'b1, 3'h0},
			'{9'h10F, 16'h00D1, 1'b0, 1'b1, 3'h4}, '{9'h10F, 16'h00C8, 1'b0, 1'b0, 3'h0},
			'{9'h106, 16'h00BF, 1'b1, 1'b0, 3'h1}};
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		// reset values and an unmapped word
		foreach (ra[i]) begin
			apb(1'b0, ra[i], 32'h0000_0000);
			`CHK(rd, rv[i])
		end
		// zero band refused, status read only
		apb(1'b1, PFC_REG_BAND, 32'h0000_0000);
		apb(1'b0, PFC_REG_BAND, 32'h0000_0000);
		`CHK(rd, 32'(PFC_BAND_RESET))
		apb(1'b0, PFC_REG_STATUS, 32'h0000_0000);
		st = rd;
		apb(1'b1, PFC_REG_STATUS, 32'hFFFF_FFFF);
		apb(1'b0, PFC_REG_STATUS, 32'h0000_0000);
		`CHK(rd, st)
		$display("test registers done");
		// continuous output, band 2.0 degrees, setpoint 20.0
		apb(1'b1, PFC_REG_SETPOINT, 32'h0000_00C8);
		drive(9'h148, 16'h00BE);
		`CHK(last_pct, 8'h32)
		drive(9'h148, 16'h00B4);
		`CHK(last_pct, 8'h64)
		drive(9'h148, 16'h00AA);
		`CHK(last_pct, 8'h64)
		drive(9'h148, 16'h00E6);
		`CHK(last_pct, 8'h00)
		// cooling folds the error: one degree above setpoint is half the band
		drive(9'h149, 16'h00D2);
		`CHK(last_pct, 8'h32)
		drive(9'h168, 16'h00C1);
		`CHK(last_pct, 8'h14)
		drive(9'h168, 16'h00BF);
		`CHK(last_pct, 8'h28)
		n0 = num_cmds;
		drive(9'h168, 16'h00C0);
		`CHK(num_cmds, n0)
		// fancoil valve as a 0/100 percentage
		drive(9'h18A, 16'h00C5);
		`CHK(last_pct, 8'h64)
		drive(9'h18A, 16'h00C8);
		`CHK(last_pct, 8'h00)
		// integral term lifts a 40 percent proportional demand to full power
		apb(1'b1, PFC_REG_INTEG, 32'h0000_0002);
		drive(9'h168, 16'h00C0);
		`CHK(last_pct, 8'h64)
		apb(1'b1, PFC_REG_INTEG, 32'h0000_0000);
		$display("test continuous done");
		foreach (rows[i]) begin
			drive(rows[i].ctrl, rows[i].temp);
			`CHK(heat_valve_on, rows[i].hv)
			`CHK(cool_valve_on, rows[i].cv)
			`CHK({fan_speed_high, fan_speed_mid, fan_speed_low}, rows[i].spd)
		end
		$display("test fancoil done");
		// valve off restarts the hold-off, so a new demand waits before switching on
		apb(1'b1, PFC_REG_TEMP, 32'h0000_00C8);
		repeat (10) @(posedge pclk);
		apb(1'b1, PFC_REG_TEMP, 32'h0000_00BF);
		repeat (10) @(posedge pclk);
		@(negedge pclk);
		`CHK({heat_valve_on, fan_speed_low}, 2'h0)
		repeat (100) @(negedge pclk);
		`CHK({heat_valve_on, fan_speed_low}, 2'h3)
		$display("test hold-off done");
		// reset in mid-run with a speed on drops every switch
		@(posedge pclk);
		presetn <= 1'b0;
		@(negedge pclk);
		`CHK({heat_valve_on, cool_valve_on, fan_speed_high, fan_speed_mid, fan_speed_low}, 5'h00)
		// release again: the bus answers at once and the control word is back at reset
		@(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, PFC_REG_CTRL, 32'h0000_0000);
		`CHK(rd, 32'(PFC_CTRL_RESET))
		$display("test reset done");
		close_out();
	end
endmodule : tb
